//--- src/avt_timing.sv
// FIFO and top of the active-video, blanking and field timing block.
// Assumes register writes arrive one subaddress per cycle from the
// serial-bus slave, and that sync inputs are active high.
`timescale 1ns/1ps

// ==========================================================
// Output FIFO
module avt_fifo #(
  parameter int W = 15,
  parameter int D = 16
) (
  // Clock and reset
  input  wire logic                   clock,
  input  wire logic                   arst_n,
  // Fill side
  input  wire logic                   in_valid,
  output logic                        in_ready,
  input  wire logic [W-1:0]           in_data,
  // Drain side
  output logic                        out_valid,
  input  wire logic                   out_ready,
  output logic [W-1:0]                out_data,
  output logic [$clog2(D):0]          level
);
  localparam int AW = $clog2(D);

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0]   cnt;
  } avt_fifo_st_t;

  avt_fifo_st_t   q;
  avt_fifo_st_t   d;
  logic [W-1:0]   mem [D];
  logic           push;
  logic           pop;

  assign in_ready  = (q.cnt != (AW+1)'(D));
  assign out_valid = (q.cnt != '0);
  assign out_data  = mem[q.rp];
  assign level     = q.cnt;
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    d = q;
    if (push) begin
      d.wp = (q.wp == AW'(D-1)) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      d.rp = (q.rp == AW'(D-1)) ? '0 : q.rp + 1'b1;
    end
    d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Storage has no reset; only pointers define content
  always_ff @(posedge clock) begin
    if (push) begin
      mem[q.wp] <= in_data;
    end
  end
endmodule : avt_fifo

// ==========================================================
// Timing top
module avt_timing #(
  parameter int FIFO_DEPTH = 16
) (
  // Clock and reset
  input  wire logic                clock,
  input  wire logic                arst_n,
  // Register port
  input  wire logic                reg_wr,
  input  wire logic                reg_rd,
  input  wire logic [7:0]          reg_addr,
  input  wire logic [7:0]          reg_wdata,
  output logic [7:0]               reg_rdata,
  // Video input
  input  wire logic                hsync_in,
  input  wire logic                vsync_in,
  input  wire logic                interlaced,
  input  wire logic                pix_valid,
  output logic                     pix_ready,
  input  wire logic [9:0]          green_in,
  input  wire logic [9:0]          blue_in,
  input  wire logic [9:0]          red_in,
  // Pixel stream out
  output logic                     out_valid,
  input  wire logic                out_ready,
  output avt_pkg::avt_pix_t        out_pix,
  // Pins and analog controls
  output logic                     vsync_output_pin,
  output logic                     field_id_output_pin,
  output logic [3:0]               bandwidth_select,
  output logic [6:0]               line_tolerance,
  output logic [12:0]              line_length
);
  localparam int LW = $clog2(FIFO_DEPTH) + 1;

  typedef struct packed {
    avt_pkg::avt_cfg_t cfg;
    logic [7:0]        rdata;
    logic              hs_prev;
    logic              vs_prev;
    logic [12:0]       pix_cnt;
    logic [11:0]       line_cnt;
    logic [12:0]       period;
    logic [12:0]       line_len;
    logic              fid;
    logic              fbit;
    logic              vs_out;
    avt_pkg::avt_pix_t pipe;
    logic              pipe_v;
    logic              ready;
  } avt_state_t;

  avt_state_t             q;
  avt_state_t             d;
  logic                   hs_edge;
  logic                   vs_edge;
  logic [12:0]            cur_pix;
  logic [11:0]            cur_line;
  logic [12:0]            diff;
  logic [11:0]            vb_lo;
  logic [11:0]            vb_hi;
  logic signed [28:0]     acc;
  logic                   f_in_ready;
  logic [LW-1:0]          f_level;
  logic                   accept;

  assign hs_edge = hsync_in && !q.hs_prev;
  assign vs_edge = vsync_in && !q.vs_prev;
  assign accept  = pix_valid && q.ready;

  always_comb begin
    d = q;
    d.hs_prev = hsync_in;
    d.vs_prev = vsync_in;

    // ========================================================
    // Register writes
    if (reg_wr) begin
      unique case (reg_addr)
        // RULE1 tolerance field store
        avt_pkg::A_TOL:   d.cfg.tol = reg_wdata[6:0];
        // RULE3 reserved value kept as written
        avt_pkg::A_RSVD:  d.cfg.rsvd = reg_wdata;
        // RULE4 shared bandwidth code
        avt_pkg::A_BW:    d.cfg.bw = reg_wdata[3:0];
        // RULE6 low byte only staged
        avt_pkg::A_ST_LO: d.cfg.start_lo = reg_wdata;
        // RULE5 RULE6 start applied on high byte
        avt_pkg::A_ST_HI: begin
          d.cfg.start = {reg_wdata[4:0], q.cfg.start_lo};
          d.cfg.mask  = reg_wdata[avt_pkg::MASK_BIT];
        end
        avt_pkg::A_SP_LO: d.cfg.stop_lo = reg_wdata;
        // RULE9 stop applied on high byte
        avt_pkg::A_SP_HI: d.cfg.stop = {reg_wdata[4:0], q.cfg.stop_lo};
        avt_pkg::A_VBS0:  d.cfg.vbs0 = reg_wdata;
        avt_pkg::A_VBS1:  d.cfg.vbs1 = reg_wdata;
        avt_pkg::A_VBL0:  d.cfg.vbl0 = reg_wdata;
        avt_pkg::A_VBL1:  d.cfg.vbl1 = reg_wdata;
        avt_pkg::A_FS0:   d.cfg.fs0 = reg_wdata;
        avt_pkg::A_FS1:   d.cfg.fs1 = reg_wdata;
        // RULE19 luma weights, low byte even
        avt_pkg::A_CG:      d.cfg.cg[7:0]  = reg_wdata;
        avt_pkg::A_CG+8'h1: d.cfg.cg[15:8] = reg_wdata;
        avt_pkg::A_CB:      d.cfg.cb[7:0]  = reg_wdata;
        avt_pkg::A_CB+8'h1: d.cfg.cb[15:8] = reg_wdata;
        avt_pkg::A_CR:      d.cfg.cr[7:0]  = reg_wdata;
        avt_pkg::A_CR+8'h1: d.cfg.cr[15:8] = reg_wdata;
        default: ;
      endcase
    end

    // ========================================================
    // Register reads; unmapped subaddresses read zero
    if (reg_rd) begin
      unique case (reg_addr)
        avt_pkg::A_TOL:     d.rdata = {1'b0, q.cfg.tol};
        avt_pkg::A_RSVD:    d.rdata = q.cfg.rsvd;
        avt_pkg::A_BW:      d.rdata = {4'h0, q.cfg.bw};
        avt_pkg::A_ST_LO:   d.rdata = q.cfg.start[7:0];
        avt_pkg::A_ST_HI:   d.rdata = {2'b00, q.cfg.mask,
                                       q.cfg.start[12:8]};
        avt_pkg::A_SP_LO:   d.rdata = q.cfg.stop[7:0];
        avt_pkg::A_SP_HI:   d.rdata = {3'b000, q.cfg.stop[12:8]};
        avt_pkg::A_VBS0:    d.rdata = q.cfg.vbs0;
        avt_pkg::A_VBS1:    d.rdata = q.cfg.vbs1;
        avt_pkg::A_VBL0:    d.rdata = q.cfg.vbl0;
        avt_pkg::A_VBL1:    d.rdata = q.cfg.vbl1;
        avt_pkg::A_FS0:     d.rdata = q.cfg.fs0;
        avt_pkg::A_FS1:     d.rdata = q.cfg.fs1;
        avt_pkg::A_CG:      d.rdata = q.cfg.cg[7:0];
        avt_pkg::A_CG+8'h1: d.rdata = q.cfg.cg[15:8];
        avt_pkg::A_CB:      d.rdata = q.cfg.cb[7:0];
        avt_pkg::A_CB+8'h1: d.rdata = q.cfg.cb[15:8];
        avt_pkg::A_CR:      d.rdata = q.cfg.cr[7:0];
        avt_pkg::A_CR+8'h1: d.rdata = q.cfg.cr[15:8];
        default:            d.rdata = 8'h00;
      endcase
    end

    // ========================================================
    // RULE21 pixel and line counters
    cur_pix  = hs_edge ? 13'h0000 : q.pix_cnt + 13'h0001;
    cur_line = vs_edge ? 12'h000
             : (hs_edge ? q.line_cnt + 12'h001 : q.line_cnt);
    d.pix_cnt  = cur_pix;
    d.line_cnt = cur_line;

    // RULE1 RULE2 tolerance window on line length
    d.period = hs_edge ? 13'h0001 : q.period + 13'h0001;
    diff = (q.period > q.line_len) ? q.period - q.line_len
                                   : q.line_len - q.period;
    if (hs_edge && (diff > {6'h00, q.cfg.tol})) begin
      d.line_len = q.period;
    end

    // RULE13 VSYNC pin follows input, untouched by offsets
    d.vs_out = vsync_in;
    // RULE18 field ID toggles only with VSYNC leading edge
    if (vs_edge) begin
      d.fid = interlaced ? !q.fid : 1'b0;
    end

    // RULE15 RULE16 RULE17 field flag at signed offsets
    if (!interlaced) begin
      d.fbit = 1'b0;
    end else if (!q.fid && ({1'b0, cur_line} ==
                 {{5{q.cfg.fs0[7]}}, q.cfg.fs0})) begin
      d.fbit = 1'b0;
    end else if (q.fid && ({1'b0, cur_line} ==
                 {{5{q.cfg.fs1[7]}}, q.cfg.fs1})) begin
      d.fbit = 1'b1;
    end

    // RULE12 RULE14 per-field blank window
    vb_lo = {4'h0, q.fid ? q.cfg.vbs1 : q.cfg.vbs0};
    vb_hi = vb_lo + {4'h0, q.fid ? q.cfg.vbl1 : q.cfg.vbl0};

    // RULE20 weighted sum, 4096 is unity
    acc = 29'($signed({1'b0, green_in}) * $signed(q.cfg.cg))
        + 29'($signed({1'b0, blue_in})  * $signed(q.cfg.cb))
        + 29'($signed({1'b0, red_in})   * $signed(q.cfg.cr));

    // ========================================================
    // Sample stage into the FIFO
    d.pipe_v = accept;
    if (accept) begin
      if (acc < 0) begin
        d.pipe.luma = 10'h000;
      end else if (acc[28:avt_pkg::LUMA_SHIFT] >
                   {7'h00, avt_pkg::LUMA_MAX}) begin
        d.pipe.luma = avt_pkg::LUMA_MAX;
      end else begin
        d.pipe.luma = acc[avt_pkg::LUMA_SHIFT +: 10];
      end
      d.pipe.vblank = (cur_line >= vb_lo) && (cur_line < vb_hi);
      // RULE8 mask forces inactive in blanking
      d.pipe.av = (cur_pix >= q.cfg.start) && (cur_pix < q.cfg.stop)
                && !(q.cfg.mask && d.pipe.vblank);
      d.pipe.field = d.fbit;
      // RULE7 start code four pixels early
      d.pipe.sav = (cur_pix == q.cfg.start - avt_pkg::SAV_LEAD);
      // RULE10 end code at stop pixel
      d.pipe.eav = (cur_pix == q.cfg.stop);
    end

    // One-cycle lag of ready leaves room for the stage in flight
    d.ready = (f_level <= LW'(FIFO_DEPTH - 3));
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      q              <= '0;
      q.cfg.tol      <= avt_pkg::RST_TOL;
      q.cfg.rsvd     <= avt_pkg::RST_RSVD;
      q.cfg.bw       <= avt_pkg::RST_BW;
      q.cfg.start    <= avt_pkg::RST_START;
      q.cfg.start_lo <= avt_pkg::RST_START[7:0];
      q.cfg.stop     <= avt_pkg::RST_STOP;
      q.cfg.stop_lo  <= avt_pkg::RST_STOP[7:0];
      q.cfg.vbs0     <= avt_pkg::RST_VBS;
      q.cfg.vbs1     <= avt_pkg::RST_VBS;
      q.cfg.vbl0     <= avt_pkg::RST_VBL;
      q.cfg.vbl1     <= avt_pkg::RST_VBL;
      q.cfg.fs0      <= avt_pkg::RST_FS;
      q.cfg.fs1      <= avt_pkg::RST_FS;
      q.cfg.cg       <= avt_pkg::RST_CG;
      q.cfg.cb       <= avt_pkg::RST_CB;
      q.cfg.cr       <= avt_pkg::RST_CR;
    end else begin
      q <= d;
    end
  end

  avt_fifo #(
    .W ($bits(avt_pkg::avt_pix_t)),
    .D (FIFO_DEPTH)
  ) u_fifo (
    .clock     (clock),
    .arst_n    (arst_n),
    .in_valid  (q.pipe_v),
    .in_ready  (f_in_ready),
    .in_data   (q.pipe),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_pix),
    .level     (f_level)
  );

  assign reg_rdata           = q.rdata;
  assign pix_ready           = q.ready;
  assign vsync_output_pin    = q.vs_out;
  assign field_id_output_pin = q.fid;
  assign bandwidth_select    = q.cfg.bw;
  assign line_tolerance      = q.cfg.tol;
  assign line_length         = q.line_len;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (!arst_n);

  start_hold_a: assert property ( // RULE6
    reg_wr && reg_addr == avt_pkg::A_ST_LO |=> $stable(q.cfg.start))
    else $error("start changed on low byte write");
  start_apply_a: assert property ( // RULE5
    reg_wr && reg_addr == avt_pkg::A_ST_HI |=>
    q.cfg.start == {$past(reg_wdata[4:0]), $past(q.cfg.start_lo)})
    else $error("start not applied on high byte");
  stop_apply_a: assert property ( // RULE9
    reg_wr && reg_addr == avt_pkg::A_SP_HI |=>
    q.cfg.stop == {$past(reg_wdata[4:0]), $past(q.cfg.stop_lo)})
    else $error("stop not applied on high byte");
  mask_blank_a: assert property ( // RULE8
    q.pipe_v && q.pipe.vblank && $past(q.cfg.mask) |-> !q.pipe.av)
    else $error("active video during masked blanking");
  prog_field_a: assert property ( // RULE17
    !interlaced [*2] |-> !q.fbit && !(q.pipe_v && q.pipe.field))
    else $error("field flag set in progressive mode");
  fid_align_a: assert property ( // RULE18
    $changed(field_id_output_pin) |-> $rose(vsync_output_pin))
    else $error("field id moved away from vsync edge");
  vs_pin_a: assert property ( // RULE13
    ##1 vsync_output_pin == $past(vsync_in))
    else $error("vsync pin does not follow input");
  len_tol_a: assert property ( // RULE2
    $changed(line_length) |-> $past(hs_edge) &&
    $past(diff) > {6'h00, $past(q.cfg.tol)})
    else $error("line length moved inside tolerance");
  bw_drive_a: assert property ( // RULE4
    reg_wr && reg_addr == avt_pkg::A_BW |=>
    bandwidth_select == $past(reg_wdata[3:0]))
    else $error("bandwidth code not driven");
  no_overflow_a: assert property (
    q.pipe_v |-> f_in_ready)
    else $error("sample stage pushed into full fifo");

  sav_seen_c: cover property (q.pipe_v && q.pipe.sav);
  field_flip_c: cover property (interlaced && $rose(q.fbit));
  fifo_full_c: cover property (!f_in_ready ##1 out_ready);
endmodule : avt_timing

//--- src/avt_pkg.sv
// Constants and types for the active-video, blanking and field timing block.
// Assumes one pixel clock; sync inputs and pixels are synchronous to it.
// Contract
// RULE1: A 7-bit tolerance sets accepted HSYNC line variation, default 03h.
// RULE2: Measured line length updates only when variation exceeds tolerance.
// RULE3: Host keeps the reserved register at 3Eh at its 04h value.
// RULE4: One 4-bit bandwidth code sets all three channels; 0h widest default.
// RULE5: Active start is a 13-bit pixel number, pixel 0 at HSYNC edge.
// RULE6: Start value takes effect only when its high byte at 41h is written.
// RULE7: Start-of-active code sits four pixels before the start pixel.
// RULE8: Mask bit 1 forces active video off during vertical blanking.
// RULE9: Stop is a 13-bit pixel number, applied only on 43h write.
// RULE10: End-of-active code is placed at the programmed stop pixel.
// RULE11: Host keeps the active pixel count between start and stop even.
// RULE12: Per-field blanking starts an unsigned line count after VSYNC edge.
// RULE13: Blank offsets move only blank flags, never the VSYNC output pin.
// RULE14: Blanking lasts a programmed per-field line count, default 1Eh.
// RULE15: Interlaced: field flag clears at signed field-0 line offset.
// RULE16: Interlaced: field flag sets at signed field-1 line offset.
// RULE17: Progressive input: field flag always 0, offsets ignored.
// RULE18: Field ID pin changes only with the VSYNC output leading edge.
// RULE19: Three 16-bit luma weights, low byte even address, green blue red.
// RULE20: Luma is the weighted sum of samples, 4096 meaning unity.
// RULE21: Pixel and line counters restart at sync edges and drive compares.
package avt_pkg;

  // ==========================================================
  // Register subaddresses
  localparam logic [7:0] A_TOL   = 8'h3d;
  localparam logic [7:0] A_RSVD  = 8'h3e;
  localparam logic [7:0] A_BW    = 8'h3f;
  localparam logic [7:0] A_ST_LO = 8'h40;
  localparam logic [7:0] A_ST_HI = 8'h41;
  localparam logic [7:0] A_SP_LO = 8'h42;
  localparam logic [7:0] A_SP_HI = 8'h43;
  localparam logic [7:0] A_VBS0  = 8'h44;
  localparam logic [7:0] A_VBS1  = 8'h45;
  localparam logic [7:0] A_VBL0  = 8'h46;
  localparam logic [7:0] A_VBL1  = 8'h47;
  localparam logic [7:0] A_FS0   = 8'h48;
  localparam logic [7:0] A_FS1   = 8'h49;
  localparam logic [7:0] A_CG    = 8'h4a;
  localparam logic [7:0] A_CB    = 8'h4c;
  localparam logic [7:0] A_CR    = 8'h4e;

  // ==========================================================
  // Field positions and reset values
  localparam int          MASK_BIT   = 5;
  localparam logic [6:0]  RST_TOL    = 7'h03;
  localparam logic [7:0]  RST_RSVD   = 8'h04;
  localparam logic [3:0]  RST_BW     = 4'h0;
  localparam logic [12:0] RST_START  = 13'h012c;
  localparam logic [12:0] RST_STOP   = 13'h062c;
  localparam logic [7:0]  RST_VBS    = 8'h05;
  localparam logic [7:0]  RST_VBL    = 8'h1e;
  localparam logic [7:0]  RST_FS     = 8'h00;
  localparam logic [15:0] RST_CG     = 16'h16e3;
  localparam logic [15:0] RST_CB     = 16'h024f;
  localparam logic [15:0] RST_CR     = 16'h06ce;
  localparam logic [12:0] SAV_LEAD   = 13'h0004;
  localparam int          LUMA_SHIFT = 12;
  localparam logic [9:0]  LUMA_MAX   = 10'h3ff;

  typedef struct packed {
    logic [9:0] luma;
    logic       av;
    logic       vblank;
    logic       field;
    logic       sav;
    logic       eav;
  } avt_pix_t;

  typedef struct packed {
    logic [6:0]  tol;
    logic [7:0]  rsvd;
    logic [3:0]  bw;
    logic [12:0] start;
    logic [7:0]  start_lo;
    logic        mask;
    logic [12:0] stop;
    logic [7:0]  stop_lo;
    logic [7:0]  vbs0;
    logic [7:0]  vbs1;
    logic [7:0]  vbl0;
    logic [7:0]  vbl1;
    logic [7:0]  fs0;
    logic [7:0]  fs1;
    logic [15:0] cg;
    logic [15:0] cb;
    logic [15:0] cr;
  } avt_cfg_t;

endpackage : avt_pkg

//--- dv/avt_sink.sv
// Model of the downstream video processor that drains the pixel stream.
// Assumes the bench picks its pace: 0 prompt, 1 random, 2 stalled.
`timescale 1ns/1ps

// ==========================================================
// Stream sink
module avt_sink (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       arst_n,
  // Stream handshake
  output logic            out_ready,
  // Pace select
  input  wire logic [1:0] mode
);
  integer      seed = 32'hd916a64b;
  logic [31:0] roll;

  // A stall may last a whole frame, so the fifo must refuse upstream
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      out_ready <= 1'b0;
    end else begin
      roll = $random(seed);
      case (mode)
        2'd0: out_ready <= 1'b1;
        2'd1: out_ready <= roll[0];
        default: out_ready <= 1'b0;
      endcase
    end
  end
endmodule : avt_sink

//--- dv/avt_timing_tb.sv
// Bench for the active-video timing block: registers, stream and pins.
// Assumes the sink model drains the stream at the pace the bench sets.
`timescale 1ns/1ps

module avt_timing_tb;
  logic              clock = 1'b0;
  logic              arst_n = 1'b0;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  logic [7:0]        reg_addr = 8'h00;
  logic [7:0]        reg_wdata = 8'h00;
  logic [7:0]        reg_rdata;
  logic              hsync_in = 1'b0;
  logic              vsync_in = 1'b0;
  logic              interlaced = 1'b0;
  logic              pix_valid = 1'b0;
  logic              pix_ready;
  logic [9:0]        green_in = 10'h000;
  logic [9:0]        blue_in = 10'h000;
  logic [9:0]        red_in = 10'h000;
  logic              out_valid;
  logic              out_ready;
  avt_pkg::avt_pix_t out_pix;
  logic              vsync_output_pin;
  logic              field_id_output_pin;
  logic [3:0]        bandwidth_select;
  logic [6:0]        line_tolerance;
  logic [12:0]       line_length;
  logic [1:0]        mode = 2'd0;
  integer            seed = 32'hd916a64b;
  int                n_errors = 0;
  int                compares = 0;
  int                cyc = 0;
  int                p = 0;
  int                l = 0;
  logic              hp = 1'b0;
  logic              vp = 1'b0;
  logic              fid = 1'b0;
  logic              fl = 1'b0;
  logic              arm = 1'b0;
  logic              mask = 1'b1;
  logic              saw_full = 1'b0;
  avt_pkg::avt_pix_t q [$];
  logic [7:0]        rst_tab [21] = '{8'h00, 8'h03, 8'h04, 8'h00, 8'h2c,
    8'h01, 8'h2c, 8'h06, 8'h05, 8'h05, 8'h1e, 8'h1e, 8'h00, 8'h00,
    8'he3, 8'h16, 8'h4f, 8'h02, 8'hce, 8'h06, 8'h00};
  // Start 8, stop 16: an even count of active pixels
  logic [15:0]       cfg [17] = '{16'h3e04, 16'h3d86, 16'h3ff5, 16'h4210,
    16'h4300, 16'h4401, 16'h4502, 16'h4602, 16'h4701, 16'h4802,
    16'h4903, 16'h4a00, 16'h4b10, 16'h4c00, 16'h4d08, 16'h4e00, 16'h4ff8};

  always #2 clock = ~clock;

  avt_timing #(.FIFO_DEPTH(16)) i_avt_timing (.clock(clock),
    .arst_n(arst_n), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .hsync_in(hsync_in), .vsync_in(vsync_in), .interlaced(interlaced),
    .pix_valid(pix_valid), .pix_ready(pix_ready), .green_in(green_in),
    .blue_in(blue_in), .red_in(red_in), .out_valid(out_valid),
    .out_ready(out_ready), .out_pix(out_pix),
    .vsync_output_pin(vsync_output_pin),
    .field_id_output_pin(field_id_output_pin),
    .bandwidth_select(bandwidth_select), .line_tolerance(line_tolerance),
    .line_length(line_length));

  avt_sink i_avt_sink (.clock(clock), .arst_n(arst_n),
    .out_ready(out_ready), .mode(mode));

  // ==========================================================
  // Checks and bus tasks
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic chk_pix(avt_pkg::avt_pix_t exp, avt_pkg::avt_pix_t got);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value out_pix expected %h seen %h", exp, got);
    end
  endtask : chk_pix

  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(logic [7:0] a, logic [7:0] e);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    chk("reg_rdata", {8'h00, e}, {8'h00, reg_rdata});
  endtask : rd

  // Vsync spans one line from pixel 5 so its rise never meets an hsync rise
  task automatic frame(int n, int per, logic il);
    for (int k = 0; k < n; k++) begin
      for (int c = 0; c < per; c++) begin
        @(posedge clock);
        interlaced <= il;
        hsync_in <= c < 2;
        vsync_in <= (k == 0 && c >= 5) || (k == 1 && c < 5);
        pix_valid <= arm && ($random(seed) % 4 != 0);
        green_in <= 10'($random(seed));
        blue_in <= 10'($random(seed));
        red_in <= 10'($random(seed));
        if (k == 0 && c == 6) arm = 1'b1;
      end
    end
    @(posedge clock);
    pix_valid <= 1'b0;
  endtask : frame

  task automatic print_verdict();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : print_verdict

  // ==========================================================
  // Reference model and output watcher
  always @(negedge clock) begin
    avt_pkg::avt_pix_t e;
    int s;
    logic vb;
    if (arst_n) begin
      chk("vsync_output_pin", 16'(vp), 16'(vsync_output_pin));
      chk("field_id_pin", 16'(fid), 16'(field_id_output_pin));
      if (hsync_in && !hp) p = 0;
      else p++;
      if (vsync_in && !vp) l = 0;
      else if (hsync_in && !hp) l++;
      if (!interlaced) fl = 1'b0;
      else if (!fid && l == 2) fl = 1'b0;
      else if (fid && l == 3) fl = 1'b1;
      vb = fid ? (l >= 2 && l < 3) : (l >= 1 && l < 3);
      e.vblank = vb;
      e.field = fl;
      e.av = p >= 8 && p < 16 && !(mask && vb);
      e.sav = p == 4;
      e.eav = p == 16;
      s = int'(green_in) * 4096 + int'(blue_in) * 2048;
      s = (s - int'(red_in) * 2048) >>> 12;
      e.luma = s < 0 ? 10'h000 : (s > 1023 ? 10'h3ff : 10'(s));
      if (pix_valid && pix_ready) q.push_back(e);
      if (arm && !pix_ready) saw_full = 1'b1;
      if (out_valid && out_ready) begin
        if (q.size() == 0) chk("pending", 16'h0001, 16'h0000);
        else chk_pix(q.pop_front(), out_pix);
      end
      if (vsync_in && !vp) fid = interlaced ? !fid : 1'b0;
      hp = hsync_in;
      vp = vsync_in;
    end
  end

  always @(posedge clock) begin
    cyc++;
    if (cyc == 5000) begin
      n_errors++;
      print_verdict();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (16) @(posedge clock);
    arst_n <= 1'b1;
    for (int a = 0; a < 21; a++) rd(8'(8'h3c + a), rst_tab[a]);
    // host keeps reserved value and even count
    for (int i = 0; i < 17; i++) wr(cfg[i][15:8], cfg[i][7:0]);
    wr(8'h40, 8'h08);
    rd(8'h40, 8'h2c);
    wr(8'h41, 8'h20);
    rd(8'h40, 8'h08);
    rd(8'h41, 8'h20);
    rd(8'h42, 8'h10);
    rd(8'h3d, 8'h06);
    rd(8'h4f, 8'hf8);
    chk("line_tolerance", 16'h0006, 16'(line_tolerance));
    chk("bandwidth_select", 16'h0005, 16'(bandwidth_select));
    mode <= 2'd1;
    frame(6, 24, 1'b0);
    chk("line_length", 16'd24, 16'(line_length));
    // Mask change between frames keeps every line gap inside tolerance
    wr(8'h41, 8'h00);
    mask = 1'b0;
    mode <= 2'd2;
    frame(6, 28, 1'b1);
    mode <= 2'd0;
    frame(6, 28, 1'b1);
    chk("line_length", 16'd24, 16'(line_length));
    // Samples still in the stage are noted already, so wait on the notes
    for (int i = 0; i < 200 && q.size() != 0; i++) @(posedge clock);
    @(negedge clock);
    chk("pending", 16'h0000, 16'(q.size()));
    chk("out_valid", 16'h0000, 16'(out_valid));
    chk("saw_full", 16'h0001, 16'(saw_full));
    print_verdict();
  end
endmodule : avt_timing_tb
